// >>> iesr_pkg.sv
// package: register map, fields and poll timing for channel enable and soft reset
`default_nettype none
package iesr_pkg;
    // ==========================================================
    // register map
    localparam int unsigned ADDR_W         = 6;
    localparam int unsigned DATA_W         = 24;
    localparam int unsigned NUM_CH         = 24;
    localparam int unsigned CH_W           = 5;
    localparam logic [5:0]  OFS_CONFIG     = 6'h1A;
    localparam logic [5:0]  OFS_CH_ENABLE  = 6'h1B;
    localparam int unsigned SOFT_RESET_BIT = 0;
    localparam logic [23:0] CH_ENABLE_RST  = 24'h000000;
    localparam logic [23:0] READ_ZERO      = 24'h000000;
    localparam logic [4:0]  LAST_CH        = 5'h17;
    localparam logic [4:0]  FIRST_CH       = 5'h00;

    // ==========================================================
    // poll timing
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned SAMPLE_NS      = 1000;
    localparam int unsigned SAMPLE_CYC_RAW = (SAMPLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SAMPLE_CYC     = (SAMPLE_CYC_RAW < 1) ? 1 : SAMPLE_CYC_RAW;
    localparam int unsigned SAMPLE_CNT_W   = 8;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } iesr_req_s;

    typedef struct packed {
        logic              valid;
        logic [CH_W-1:0]   chan;
        logic              level;
    } iesr_sample_s;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SEEK   = 3'b010,
        ST_SAMPLE = 3'b100
    } iesr_state_e;
endpackage
`default_nettype wire

// >>> iesr_regfile.sv
// small register store: channel enable word with registered read data
`default_nettype none
module iesr_regfile (
    input  wire logic                       sys_clk_i,
    input  wire logic                       clr_i,
    input  wire logic                       we_i,
    input  wire logic                       re_i,
    input  wire logic [iesr_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [iesr_pkg::DATA_W-1:0] wdata_i,
    output logic      [iesr_pkg::DATA_W-1:0] rdata_o,
    output logic      [iesr_pkg::DATA_W-1:0] enable_o
);
    logic [iesr_pkg::DATA_W-1:0] enable_q;

    // ==========================================================
    // enable word store, cleared by any reset
    always_ff @(posedge sys_clk_i) begin
        if (clr_i) begin
            enable_q <= iesr_pkg::CH_ENABLE_RST;
        end else if (we_i && addr_i == iesr_pkg::OFS_CH_ENABLE) begin
            enable_q <= wdata_i;
        end
    end

    // ==========================================================
    // registered read data
    always_ff @(posedge sys_clk_i) begin
        if (clr_i) begin
            rdata_o <= iesr_pkg::READ_ZERO;
        end else if (re_i) begin
            if (addr_i == iesr_pkg::OFS_CH_ENABLE) begin
                rdata_o <= enable_q;
            end else begin
                rdata_o <= iesr_pkg::READ_ZERO;
            end
        end
    end

    assign enable_o = enable_q;
endmodule
`default_nettype wire

// >>> iesr_top.sv
// channel enable register, soft reset and enable-gated polling sequencer
// Behaviour
// - writing one to bit 0 of the configuration register resets the whole block, zero does not.
// - the channel enable register sits at offset 1Bh and resets to zero, all channels off.
// - enable bit n of the 24-bit register governs switch input channel n, one enables it.
// - a channel disabled at its seek cycle is passed over by the poll sequence and not sampled.
// - every enable bit is read/write and a read returns the value last written.
// Timing
// poll start is taken only while idle; busy rises on the next cycle.
// each enabled channel costs one seek cycle and then a full sample window.
// disabled channels are jumped over inside that single seek cycle.
// the sample strobe follows the last window cycle and stands for one cycle.
// sample channel and level hold until the next strobe.
// soft reset pulses one cycle after the config write and clears like rst_i.
// an enable register write that meets the soft reset pulse is lost; the reset wins.
// a read in the same cycle as a write returns the word before that write.
// config bits other than the reset bit are not stored and read back as zero.
// enable changes during a window do not cut that window short.
`default_nettype none
module iesr_top (
    // clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    // host register access
    input  wire iesr_pkg::iesr_req_s         req_i,
    // poll control and switch levels
    input  wire logic                        poll_start_i,
    input  wire logic [iesr_pkg::NUM_CH-1:0] switch_in_i,
    // register read-back and enable view
    output logic      [iesr_pkg::DATA_W-1:0] rdata_o,
    output logic      [iesr_pkg::NUM_CH-1:0] ch_enable_o,
    // poll results and status
    output var iesr_pkg::iesr_sample_s       sample_o,
    output logic                             poll_busy_o,
    output logic                             soft_reset_o
);
    logic                               soft_rst_q;
    logic                               clr;
    logic [iesr_pkg::DATA_W-1:0]        enable;
    iesr_pkg::iesr_state_e              state_q;
    logic [iesr_pkg::CH_W-1:0]          chan_q;
    logic [iesr_pkg::SAMPLE_CNT_W-1:0]  cnt_q;
    logic [iesr_pkg::NUM_CH-1:0]        remain;
    logic                               any_left;
    logic [iesr_pkg::CH_W-1:0]          next_ch;
    logic                               cfg_hit;
    logic                               start_ok;
    logic                               seek_hit;
    logic                               win_end;
    logic                               at_last;
    logic                               step_ch;
    logic [iesr_pkg::NUM_CH-1:0]        level_sel;
    logic                               sample_valid_q;
    logic [iesr_pkg::CH_W-1:0]          sample_chan_q;
    logic                               sample_level_q;

    // ==========================================================
    // config write decode: only the reset bit is live, other bits drop
    assign cfg_hit = req_i.wr && (req_i.addr == iesr_pkg::OFS_CONFIG)
                     && req_i.wdata[iesr_pkg::SOFT_RESET_BIT];

    // soft reset: one-cycle pulse, a config write inside it rearms it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= cfg_hit;
        end
    end

    // every state flop below clears on either reset source
    assign clr          = rst_i | soft_rst_q;
    assign soft_reset_o = soft_rst_q;

    // ==========================================================
    // register store
    iesr_regfile u_regs (
        .sys_clk_i (sys_clk_i),
        .clr_i     (clr),
        .we_i      (req_i.wr),
        .re_i      (req_i.rd),
        .addr_i    (req_i.addr),
        .wdata_i   (req_i.wdata),
        .rdata_o   (rdata_o),
        .enable_o  (enable)
    );

    assign ch_enable_o = enable;

    // ==========================================================
    // next enabled channel at or above the search start
    always_comb begin
        next_ch  = iesr_pkg::FIRST_CH;
        any_left = 1'b0;
        for (int i = iesr_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (remain[i]) begin
                next_ch  = i[iesr_pkg::CH_W-1:0];
                any_left = 1'b1;
            end
        end
    end

    // mask of channels still to visit, enable-gated
    for (genvar g = 0; g < iesr_pkg::NUM_CH; g++) begin : g_remain
        assign remain[g] = enable[g] && (g >= chan_q);
    end

    // ==========================================================
    // poll step decode shared by the sequencer processes
    // one decode so every flop below acts on the same condition
    assign start_ok = (state_q == iesr_pkg::ST_IDLE) && poll_start_i;
    assign seek_hit = (state_q == iesr_pkg::ST_SEEK) && any_left;
    assign win_end  = (state_q == iesr_pkg::ST_SAMPLE)
                      && (cnt_q == iesr_pkg::SAMPLE_CNT_W'(iesr_pkg::SAMPLE_CYC - 1));
    assign at_last  = (chan_q == iesr_pkg::LAST_CH);
    assign step_ch  = win_end && !at_last;

    // ==========================================================
    // poll sequencer state
    // a stale or corrupt code falls back to idle
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            state_q <= iesr_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                iesr_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        state_q <= iesr_pkg::ST_SEEK;
                    end
                end
                iesr_pkg::ST_SEEK: begin
                    if (seek_hit) begin
                        state_q <= iesr_pkg::ST_SAMPLE;
                    end else begin
                        state_q <= iesr_pkg::ST_IDLE;
                    end
                end
                iesr_pkg::ST_SAMPLE: begin
                    if (win_end && at_last) begin
                        state_q <= iesr_pkg::ST_IDLE;
                    end else if (win_end) begin
                        state_q <= iesr_pkg::ST_SEEK;
                    end
                end
                default: begin
                    state_q <= iesr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // channel pointer: restart, jump to next enabled, step past a sample
    // stepping past the last channel never happens, the poll ends there
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            chan_q <= iesr_pkg::FIRST_CH;
        end else if (start_ok) begin
            chan_q <= iesr_pkg::FIRST_CH;
        end else if (seek_hit) begin
            chan_q <= next_ch;
        end else if (step_ch) begin
            chan_q <= chan_q + 5'h01;
        end
    end

    // ==========================================================
    // sample window counter, cleared as each window is entered
    // it parks on its end value until the next seek clears it
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            cnt_q <= '0;
        end else if (seek_hit) begin
            cnt_q <= '0;
        end else if ((state_q == iesr_pkg::ST_SAMPLE) && !win_end) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // ==========================================================
    // switch level of the current channel, one-hot select per input
    // keeps the pointer from indexing past the top input
    for (genvar g = 0; g < iesr_pkg::NUM_CH; g++) begin : g_level
        assign level_sel[g] = switch_in_i[g] && (chan_q == iesr_pkg::CH_W'(g));
    end

    // ==========================================================
    // sample strobe: one cycle after each enabled window ends
    // only channels enabled at their seek cycle reach a window, so only they strobe
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            sample_valid_q <= 1'b0;
        end else begin
            sample_valid_q <= win_end;
        end
    end

    // sample channel, held until the next window ends
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            sample_chan_q <= iesr_pkg::FIRST_CH;
        end else if (win_end) begin
            sample_chan_q <= chan_q;
        end
    end

    // sample level, held until the next window ends
    // taken at the last window cycle so the input has settled
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            sample_level_q <= 1'b0;
        end else if (win_end) begin
            sample_level_q <= |level_sel;
        end
    end

    // sample carrier out of the flops
    assign sample_o = '{valid: sample_valid_q, chan: sample_chan_q, level: sample_level_q};

    // ==========================================================
    // busy in every sequencer state but idle
    assign poll_busy_o = (state_q != iesr_pkg::ST_IDLE);
endmodule
`default_nettype wire

// >>> iesr_top_sva.sv
// checker for enable register, soft reset and poll skipping
`default_nettype none
module iesr_top_sva (
    input wire logic                        sys_clk_i,
    input wire logic                        rst_i,
    input wire iesr_pkg::iesr_req_s         req_i,
    input wire logic [iesr_pkg::NUM_CH-1:0] ch_enable_o,
    input wire logic [iesr_pkg::DATA_W-1:0] rdata_o,
    input wire iesr_pkg::iesr_sample_s      sample_o,
    input wire logic                        poll_busy_o,
    input wire logic                        soft_reset_o
);
    // ==========================================================
    // decoded accesses; enable accesses are lost in the soft reset cycle
    logic en_wr;
    logic cfg_wr;
    logic en_rd;
    assign en_wr  = req_i.wr && req_i.addr == iesr_pkg::OFS_CH_ENABLE && !soft_reset_o;
    assign cfg_wr = req_i.wr && req_i.addr == iesr_pkg::OFS_CONFIG
                    && req_i.wdata[iesr_pkg::SOFT_RESET_BIT];
    assign en_rd  = req_i.rd && req_i.addr == iesr_pkg::OFS_CH_ENABLE && !soft_reset_o;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========================================================
    // properties
    wr_lands_a: assert property (en_wr |=> ch_enable_o == $past(req_i.wdata))
        else $error("enable write lost");
    cfg_go_a: assert property (cfg_wr |=> soft_reset_o)
        else $error("soft reset missing");
    cfg_only_a: assert property (soft_reset_o |-> $past(cfg_wr))
        else $error("soft reset without cause");
    srst_clr_a: assert property (soft_reset_o |=> ch_enable_o == '0 && !poll_busy_o)
        else $error("soft reset left state");
    rd_back_a: assert property (en_rd |=> rdata_o == $past(ch_enable_o))
        else $error("read data wrong");
    skip_off_a: assert property (sample_o.valid |-> ch_enable_o[sample_o.chan])
        else $error("disabled channel sampled");
endmodule
bind iesr_top iesr_top_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i),
    .ch_enable_o(ch_enable_o), .rdata_o(rdata_o), .sample_o(sample_o),
    .poll_busy_o(poll_busy_o), .soft_reset_o(soft_reset_o));
`default_nettype wire

// >>> iesr_host.sv
// host model: register access pulses off the falling edge
`default_nettype none
module iesr_host (
    input  wire logic                        sys_clk_i,
    input  wire logic [iesr_pkg::DATA_W-1:0] rdata_i,
    output var  iesr_pkg::iesr_req_s         req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req_o = '0;
    // one access pulse; released fields show the inverse, not the old value
    task automatic acc(input logic w, input logic [5:0] a, input logic [23:0] v);
        @(negedge sys_clk_i);
        req_o = '{wr: w, rd: !w, addr: a, wdata: v};
        @(negedge sys_clk_i);
        req_o = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~v};
    endtask
    // read data is settled one falling edge after the pulse
    task automatic rd(input logic [5:0] a, output logic [23:0] v);
        acc(1'h0, a, 24'h000000);
        v = rdata_i;
    endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// testbench: register access, poll skipping and soft reset
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   sys_clk_i;
    logic                   rst_i;
    logic                   poll_start_i;
    logic                   poll_busy_o;
    logic                   soft_reset_o;
    logic [23:0]            switch_in_i;
    logic [23:0]            rdata_o;
    logic [23:0]            ch_enable_o;
    logic [23:0]            d;
    iesr_pkg::iesr_req_s    req_i;
    iesr_pkg::iesr_sample_s sample_o;
    int                     errors;
    int                     tests_run;
    int                     n;
    int                     last;
    iesr_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i),
        .poll_start_i(poll_start_i), .switch_in_i(switch_in_i), .rdata_o(rdata_o),
        .ch_enable_o(ch_enable_o), .sample_o(sample_o), .poll_busy_o(poll_busy_o),
        .soft_reset_o(soft_reset_o));
    iesr_host u_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o), .req_o(req_i));
    // 50 ns clock
    initial begin
        sys_clk_i = 1'h0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // start a poll and watch pulses until idle or the stop count
    task automatic poll(input int stop);
        n = 0;
        @(negedge sys_clk_i) poll_start_i = 1'h1;
        @(negedge sys_clk_i) poll_start_i = 1'h0;
        for (int i = 0; i <= 900; i++) begin
            if (i == 900) begin
                errors++;
                print_verdict();
            end
            if (sample_o.valid === 1'h1) begin
                n++;
                last = int'(sample_o.chan);
                chk("level", 24'(sample_o.level), 24'(switch_in_i[sample_o.chan]));
            end
            if (poll_busy_o !== 1'h1 || i == stop) break;
            @(negedge sys_clk_i);
        end
    endtask
    // main sequence
    initial begin
        errors = 0;
        tests_run = 0;
        rst_i = 1'h1;
        poll_start_i = 1'h0;
        switch_in_i = 24'h800000;
        repeat (4) @(negedge sys_clk_i);
        rst_i = 1'h0;
        u_host.rd(6'h1B, d);
        chk("enable reset", d, 24'h000000);
        u_host.acc(1'h1, 6'h1B, 24'hA5A5A5);
        u_host.acc(1'h1, 6'h1B, 24'h5A5A5B);
        chk("enable port", ch_enable_o, 24'h5A5A5B);
        u_host.rd(6'h05, d);
        chk("unmapped", d, 24'h000000);
        u_host.acc(1'h1, 6'h1A, 24'hFFFFFE);
        chk("no soft reset", 24'(soft_reset_o), 24'h000000);
        u_host.rd(6'h1B, d);
        chk("enable rw", d, 24'h5A5A5B);
        u_host.acc(1'h1, 6'h1C, 24'h000000);
        chk("enable kept", ch_enable_o, 24'h5A5A5B);
        $display("test registers done");
        u_host.acc(1'h1, 6'h1B, 24'h800001);
        poll(999);
        chk("pulses", 24'(n), 24'h000002);
        chk("last chan", 24'(last), 24'h000017);
        $display("test poll done");
        u_host.acc(1'h1, 6'h1B, 24'hFFFFFF);
        poll(30);
        chk("busy before", 24'(poll_busy_o), 24'h000001);
        u_host.acc(1'h1, 6'h1A, 24'h000001);
        chk("soft pulse", 24'(soft_reset_o), 24'h000001);
        @(negedge sys_clk_i);
        chk("busy", 24'(poll_busy_o), 24'h000000);
        u_host.rd(6'h1B, d);
        chk("enable cleared", d, 24'h000000);
        $display("test soft reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
